// >>> src/pli_pkg.sv
/*
  pli_pkg: constants, field positions and enumerations shared by the
  program level interrupt block and its context memory.
  assumes: compiled before every other design file.
*/
package pli_pkg;
  localparam int unsigned PLI_LEVELS = 16;
  localparam int unsigned PLI_LVL_W = 4;
  localparam int unsigned PLI_WORD_W = 16;
  localparam int unsigned PLI_INT_SRC_W = 11;
  localparam int unsigned PLI_CTX_W = 24; // saved counter plus low status byte
  // levels with hardware request inputs
  localparam logic [3:0] PLI_LVL_INTERNAL = 4'he;
  localparam logic [3:0] PLI_LVL_TOP = 4'hf;
  localparam logic [3:0] PLI_LVL_EXT_LO = 4'ha;
  // reset values
  localparam logic [15:0] PLI_ENABLE_RST = 16'h0000;
  localparam logic [15:0] PLI_DETECT_RST = 16'h0000;
  localparam logic [10:0] PLI_INT_EN_RST = 11'h000;
  localparam logic [3:0] PLI_LEVEL_RST = 4'h0;
  localparam logic [7:0] PLI_STATUS_LOW_RST = 8'h00;
  // machine identification flag value, arbitrary
  localparam logic PLI_MACHINE_TYPE = 1'b1;
  // per-level status byte positions
  localparam int unsigned PLI_ST_ALT_PAGE = 0;
  localparam int unsigned PLI_ST_ROUND = 1;
  localparam int unsigned PLI_ST_K = 2;
  localparam int unsigned PLI_ST_Z = 3;
  localparam int unsigned PLI_ST_Q = 4;
  localparam int unsigned PLI_ST_O = 5;
  localparam int unsigned PLI_ST_C = 6;
  localparam int unsigned PLI_ST_M = 7;
  // shared upper status byte positions
  localparam int unsigned PLI_ST_IRQ_ON = 8;
  localparam int unsigned PLI_ST_PAGING = 9;
  localparam int unsigned PLI_ST_EXT_ADDR = 10;
  localparam int unsigned PLI_ST_MACHINE = 11;
  localparam int unsigned PLI_ST_LEVEL_LO = 12;
  // internal source carrying the error indicator
  localparam int unsigned PLI_INT_ERR_BIT = 5;
  // level change time bound
  localparam int unsigned PLI_CLK_MHZ = 40;
  localparam int unsigned PLI_SWITCH_MAX_NS = 5000;
  localparam int unsigned PLI_SWITCH_MAX_CYC = PLI_SWITCH_MAX_NS * PLI_CLK_MHZ / 1000;
  // special register transfers
  typedef enum logic [1:0] {
    PLI_OP_READ,
    PLI_OP_WRITE,
    PLI_OP_MSET,
    PLI_OP_MCLR
  } pli_op_t;
  typedef enum logic [2:0] {
    PLI_TGT_ENABLE,
    PLI_TGT_DETECT,
    PLI_TGT_INT_ENABLE,
    PLI_TGT_INT_CODE,
    PLI_TGT_STATUS
  } pli_tgt_t;
endpackage

// >>> src/pli_ctx_mem.sv
/*
  pli_ctx_mem: one saved counter and status byte per program level.
  assumes: single clock, one write and one registered read per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module pli_ctx_mem (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [pli_pkg::PLI_LVL_W-1:0] wr_addr,
  input wire logic [pli_pkg::PLI_CTX_W-1:0] wr_data,
  input wire logic [pli_pkg::PLI_LVL_W-1:0] rd_addr,
  output logic [pli_pkg::PLI_CTX_W-1:0] rd_data
);
  import pli_pkg::*;
  logic [PLI_CTX_W-1:0] mem [PLI_LEVELS];

  // storage and registered read
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // pli_ctx_mem
`default_nettype wire

// >>> src/program_level_interrupt.sv
/*
  program_level_interrupt: enable and detect registers, priority encoder,
  current and previous level, level change sequencer, status indicators.
  assumes: one processor clock; instructions arrive as one-cycle strobes
  from the sequencer; request pins are asynchronous to clk_sys.
*/
// Summary of operation
// - sixteen levels, fifteen highest, zero lowest
// - each level keeps own counter and status
// - sixteen-bit enable and detect registers, per level
// - enable by program only; detect also hardware
// - pending code is highest enabled detected level
// - current level selects the active context
// - pending differing from current starts level change
// - raising needs higher level and system on
// - block, save, copy previous, load, restore, fetch
// - whole change within five microseconds
// - raise on request; drop when pending code falls below current
// - pins set bits 15,13-10; 14 internal only
// - level 14 from masked internal detect sources
// - levels 0-9 detected by microprogram only
// - levels 10-13 shared by many devices
// - any level activatable by software bits
// - eight per-level indicators, transferable to accumulator
// - static overflow sticky; carry, dynamic overflow follow
// - error indicator sticky, feeds internal interrupt
// - upper eight status bits shared by levels
// - extended addressing bit selects wide addressing
// - copy, masked set, masked clear on registers
// - eleven-bit internal enable from accumulator
`timescale 1ns/1ps
`default_nettype none
module program_level_interrupt (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] ext_irq_mid,
  input wire logic ext_irq_top,
  input wire logic [pli_pkg::PLI_INT_SRC_W-1:0] int_src,
  input wire logic instr_valid,
  input wire pli_pkg::pli_op_t instr_op,
  input wire pli_pkg::pli_tgt_t instr_tgt,
  input wire logic [pli_pkg::PLI_WORD_W-1:0] acc_in,
  input wire logic give_up,
  input wire logic instr_boundary,
  input wire logic [pli_pkg::PLI_WORD_W-1:0] live_program_counter,
  input wire logic alu_update,
  input wire logic alu_carry,
  input wire logic alu_dyn_ovf,
  input wire logic alu_ovf_event,
  input wire logic alu_err_event,
  input wire logic alu_link,
  output logic [pli_pkg::PLI_WORD_W-1:0] read_data,
  output logic read_valid,
  output logic [pli_pkg::PLI_LVL_W-1:0] current_level,
  output logic [pli_pkg::PLI_LVL_W-1:0] previous_level,
  output logic [pli_pkg::PLI_LVL_W-1:0] pending_level_code,
  output logic switch_busy,
  output logic fetch_req,
  output logic pc_load,
  output logic [pli_pkg::PLI_WORD_W-1:0] pc_out,
  output logic [pli_pkg::PLI_WORD_W-1:0] status_word
);
  import pli_pkg::*;

  typedef enum logic [2:0] {
    PLI_S_IDLE,
    PLI_S_BLOCK,
    PLI_S_SAVE,
    PLI_S_SWAP,
    PLI_S_READ,
    PLI_S_LOAD
  } pli_state_t;

  // highest set bit of a word, as a level number
  function automatic logic [3:0] pli_prio16(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // copy, masked set or masked clear of a register
  function automatic logic [15:0] pli_apply(input logic [15:0] cur, input pli_op_t op,
                                            input logic [15:0] a);
    logic [15:0] r;
    r = cur;
    unique case (op)
      PLI_OP_WRITE: r = a;
      PLI_OP_MSET: r = cur | a;
      PLI_OP_MCLR: r = cur & ~a;
      PLI_OP_READ: r = cur;
    endcase
    return r;
  endfunction

  logic [3:0] mid_meta, mid_sync;
  logic top_meta, top_sync;
  logic [15:0] level_enable, next_level_enable;
  logic [15:0] level_detect, next_level_detect;
  logic [10:0] internal_irq_enable, next_internal_irq_enable;
  logic [10:0] int_detect, next_int_detect;
  logic [3:0] next_current_level, next_previous_level, next_pending_level_code;
  logic [3:0] target_level, next_target_level;
  logic [7:0] status_low, next_status_low;
  logic irq_system_on_flag, next_irq_system_on_flag;
  logic paging_on_flag, next_paging_on_flag;
  logic extended_addressing_flag, next_extended_addressing_flag;
  logic [15:0] next_read_data, next_pc_out, next_status_word;
  logic next_read_valid, next_switch_busy, next_fetch_req, next_pc_load;
  pli_state_t state, next_state;
  logic [15:0] pend_vec;
  logic [3:0] pend_code;
  logic [10:0] int_active;
  logic ctx_wr, take_instr;
  logic [PLI_CTX_W-1:0] ctx_rd;

  // request pins pass two flops before use
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mid_meta <= 4'h0;
      mid_sync <= 4'h0;
      top_meta <= 1'b0;
      top_sync <= 1'b0;
    end else begin
      mid_meta <= ext_irq_mid;
      mid_sync <= mid_meta;
      top_meta <= ext_irq_top;
      top_sync <= top_meta;
    end
  end

  // saved counter and status byte per level
  pli_ctx_mem u_ctx (
    .clk_sys(clk_sys),
    .wr_en(ctx_wr),
    .wr_addr(current_level),
    .wr_data({live_program_counter, status_low}),
    .rd_addr(target_level),
    .rd_data(ctx_rd)
  );

  // pending code from enabled detected levels
  always_comb begin
    int_active = int_detect & internal_irq_enable;
    pend_vec = level_enable & level_detect;
    pend_code = pli_prio16(pend_vec);
    take_instr = instr_valid && (state == PLI_S_IDLE);
    ctx_wr = (state == PLI_S_SAVE);
  end

  // register transfers, hardware requests and indicators
  always_comb begin
    next_level_enable = level_enable;
    next_level_detect = level_detect;
    next_internal_irq_enable = internal_irq_enable;
    next_int_detect = int_detect;
    next_status_low = status_low;
    next_irq_system_on_flag = irq_system_on_flag;
    next_paging_on_flag = paging_on_flag;
    next_extended_addressing_flag = extended_addressing_flag;
    next_read_data = read_data;
    next_read_valid = 1'b0;
    if (take_instr) begin
      unique case (instr_tgt)
        PLI_TGT_ENABLE: begin
          next_level_enable = pli_apply(level_enable, instr_op, acc_in);
          next_read_data = level_enable;
        end
        PLI_TGT_DETECT: begin
          next_level_detect = pli_apply(level_detect, instr_op, acc_in);
          next_read_data = level_detect;
        end
        PLI_TGT_INT_ENABLE: begin
          next_internal_irq_enable = 11'(pli_apply({5'h00, internal_irq_enable}, instr_op, acc_in));
          next_read_data = {5'h00, internal_irq_enable};
        end
        PLI_TGT_INT_CODE: begin
          // reading the code consumes the source it reports
          next_read_data = {12'h000, pli_prio16({5'h00, int_active})};
          if (instr_op == PLI_OP_READ && |int_active) begin
            next_int_detect[pli_prio16({5'h00, int_active})] = 1'b0;
          end
        end
        PLI_TGT_STATUS: begin
          next_read_data = status_word;
          if (instr_op != PLI_OP_READ) begin
            next_status_low = 8'(pli_apply({8'h00, status_low}, instr_op, {8'h00, acc_in[7:0]}));
            next_irq_system_on_flag = 1'(pli_apply({15'h0000, irq_system_on_flag}, instr_op,
                                                   {15'h0000, acc_in[PLI_ST_IRQ_ON]}));
            next_paging_on_flag = 1'(pli_apply({15'h0000, paging_on_flag}, instr_op,
                                               {15'h0000, acc_in[PLI_ST_PAGING]}));
            next_extended_addressing_flag = 1'(pli_apply({15'h0000, extended_addressing_flag}, instr_op,
                                                         {15'h0000, acc_in[PLI_ST_EXT_ADDR]}));
          end
        end
        default: next_read_data = 16'h0000;
      endcase
      next_read_valid = (instr_op == PLI_OP_READ);
    end
    // alu results on the active level; sticky events win over a program clear
    if (alu_update) begin
      next_status_low[PLI_ST_C] = alu_carry;
      next_status_low[PLI_ST_Q] = alu_dyn_ovf;
      next_status_low[PLI_ST_M] = alu_link;
      next_status_low[PLI_ST_O] = next_status_low[PLI_ST_O] | alu_ovf_event;
      next_status_low[PLI_ST_Z] = next_status_low[PLI_ST_Z] | alu_err_event;
    end
    // give-up clears the running level's request
    if (give_up) begin
      next_level_detect[current_level] = 1'b0;
    end
    // restore the new level's indicators
    if (state == PLI_S_LOAD) begin
      next_status_low = ctx_rd[7:0];
    end
    // hardware sets win over program clears
    next_int_detect = next_int_detect | int_src;
    next_int_detect[PLI_INT_ERR_BIT] = next_int_detect[PLI_INT_ERR_BIT] | status_low[PLI_ST_Z];
    next_level_detect[PLI_LVL_INTERNAL] = next_level_detect[PLI_LVL_INTERNAL] | (|int_active);
    for (int i = 0; i < 4; i++) begin
      next_level_detect[PLI_LVL_EXT_LO + 4'(i)] = next_level_detect[PLI_LVL_EXT_LO + 4'(i)]
                                                  | mid_sync[i];
    end
    next_level_detect[PLI_LVL_TOP] = next_level_detect[PLI_LVL_TOP] | top_sync;
  end

  // level change sequencer
  always_comb begin
    next_state = state;
    next_current_level = current_level;
    next_previous_level = previous_level;
    next_target_level = target_level;
    next_pending_level_code = pend_code;
    next_switch_busy = (state != PLI_S_IDLE);
    next_fetch_req = 1'b0;
    next_pc_load = 1'b0;
    next_pc_out = pc_out;
    unique case (state)
      PLI_S_IDLE: begin
        // raise only with system on; drop at any instruction boundary with pending below current
        if (instr_boundary && pending_level_code != current_level &&
            (pending_level_code < current_level || irq_system_on_flag)) begin
          next_state = PLI_S_BLOCK;
          next_target_level = pending_level_code;
          next_switch_busy = 1'b1;
        end
      end
      PLI_S_BLOCK: next_state = PLI_S_SAVE;
      PLI_S_SAVE: next_state = PLI_S_SWAP;
      PLI_S_SWAP: begin
        next_previous_level = current_level;
        next_current_level = target_level;
        next_state = PLI_S_READ;
      end
      PLI_S_READ: next_state = PLI_S_LOAD;
      PLI_S_LOAD: begin
        next_pc_out = ctx_rd[PLI_CTX_W-1:8];
        next_pc_load = 1'b1;
        next_fetch_req = 1'b1;
        next_switch_busy = 1'b0;
        next_state = PLI_S_IDLE;
      end
      default: next_state = PLI_S_IDLE;
    endcase
  end

  // assembled status word
  always_comb begin
    next_status_word = {next_current_level, PLI_MACHINE_TYPE, next_extended_addressing_flag,
                        next_paging_on_flag, next_irq_system_on_flag, next_status_low};
  end

  // state registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level_enable <= PLI_ENABLE_RST;
      level_detect <= PLI_DETECT_RST;
      internal_irq_enable <= PLI_INT_EN_RST;
      int_detect <= 11'h000;
      status_low <= PLI_STATUS_LOW_RST;
      irq_system_on_flag <= 1'b0;
      paging_on_flag <= 1'b0;
      extended_addressing_flag <= 1'b0;
      read_data <= 16'h0000;
      read_valid <= 1'b0;
      state <= PLI_S_IDLE;
      current_level <= PLI_LEVEL_RST;
      previous_level <= PLI_LEVEL_RST;
      target_level <= PLI_LEVEL_RST;
      pending_level_code <= PLI_LEVEL_RST;
      switch_busy <= 1'b0;
      fetch_req <= 1'b0;
      pc_load <= 1'b0;
      pc_out <= 16'h0000;
      status_word <= 16'h0000;
    end else begin
      level_enable <= next_level_enable;
      level_detect <= next_level_detect;
      internal_irq_enable <= next_internal_irq_enable;
      int_detect <= next_int_detect;
      status_low <= next_status_low;
      irq_system_on_flag <= next_irq_system_on_flag;
      paging_on_flag <= next_paging_on_flag;
      extended_addressing_flag <= next_extended_addressing_flag;
      read_data <= next_read_data;
      read_valid <= next_read_valid;
      state <= next_state;
      current_level <= next_current_level;
      previous_level <= next_previous_level;
      target_level <= next_target_level;
      pending_level_code <= next_pending_level_code;
      switch_busy <= next_switch_busy;
      fetch_req <= next_fetch_req;
      pc_load <= next_pc_load;
      pc_out <= next_pc_out;
      status_word <= next_status_word;
    end
  end
endmodule // program_level_interrupt
`default_nettype wire

// >>> tb/pli_properties.sv
/*
  pli_properties: port checks on the level change and register transfers.
  assumes: bound to program_level_interrupt, one clock, async low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pli_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire pli_pkg::pli_op_t instr_op,
  input wire logic instr_boundary,
  input wire logic read_valid,
  input wire logic [3:0] current_level,
  input wire logic [3:0] previous_level,
  input wire logic [3:0] pending_level_code,
  input wire logic switch_busy,
  input wire logic fetch_req,
  input wire logic pc_load,
  input wire logic [15:0] status_word
);
  import pli_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // level change sequence shape and bound
  a_busy_length: assert property ($rose(switch_busy) |-> switch_busy [*5] ##1 !switch_busy)
    else $error("busy length wrong");
  a_fetch_end: assert property ($rose(switch_busy) |-> ##5 (fetch_req && pc_load))
    else $error("fetch not at sequence end");
  a_fetch_alone: assert property (fetch_req |-> pc_load && !switch_busy && $past(switch_busy))
    else $error("fetch outside sequence");
  a_level_copy: assert property ($changed(current_level) |-> switch_busy && previous_level == $past(current_level))
    else $error("level moved outside sequence");
  a_start_cause: assert property ($rose(switch_busy) |-> $past(instr_boundary) && $past(pending_level_code) != $past(current_level))
    else $error("change without cause");
  a_raise_gate: assert property ($rose(switch_busy) && $past(pending_level_code) > $past(current_level) |-> $past(status_word[8]))
    else $error("raise with system off");
  // register transfer answers
  a_read_answer: assert property (instr_valid && instr_op == PLI_OP_READ && !switch_busy && !fetch_req |=> read_valid)
    else $error("read not answered");
  a_read_cause: assert property (read_valid |-> $past(instr_valid) && $past(instr_op) == PLI_OP_READ)
    else $error("spurious read answer");
  a_level_field: assert property (!switch_busy |-> status_word[15:12] == current_level)
    else $error("status level field wrong");
  // main scenarios
  c_change: cover property ($rose(switch_busy));
  c_drop: cover property (fetch_req && current_level < previous_level);
  c_read: cover property (read_valid);
endmodule // pli_checker
bind program_level_interrupt pli_checker u_chk (.clk_sys, .rst_n, .instr_valid, .instr_op, .instr_boundary,
  .read_valid, .current_level, .previous_level, .pending_level_code, .switch_busy, .fetch_req, .pc_load,
  .status_word);
`default_nettype wire

// >>> tb/pli_src_model.sv
/*
  pli_src_model: request devices and instruction sequencer around the block.
  assumes: driven by tb_top, changes only just after rising clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module pli_src_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] dev_mid,
  input wire logic dev_top,
  input wire logic slow,
  input wire logic switch_busy,
  input wire logic pc_load,
  input wire logic [15:0] pc_out,
  output logic [3:0] ext_irq_mid,
  output logic ext_irq_top,
  output logic instr_boundary,
  output logic [15:0] live_program_counter
);
  logic [1:0] phase;
  // devices, sequencer boundary and running counter
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_irq_mid <= 4'h0;
      ext_irq_top <= 1'b0;
      instr_boundary <= 1'b0;
      phase <= 2'h0;
      live_program_counter <= 16'h0100;
    end else begin
      ext_irq_mid <= dev_mid;
      ext_irq_top <= dev_top;
      phase <= phase + 2'h1;
      instr_boundary <= !slow || phase == 2'h3;
      if (pc_load) begin
        // a level never saved yet starts its program at a fixed counter
        live_program_counter <= $isunknown(pc_out) ? 16'h0500 : pc_out;
      end else if (!switch_busy) begin
        live_program_counter <= live_program_counter + 16'h0001;
      end
    end
  end
endmodule // pli_src_model
`default_nettype wire

// >>> tb/tb_top.sv
/*
  tb_top: directed scenarios for the program level interrupt block.
  assumes: package, design, checker and source model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pli_pkg::*;
  logic clk_sys, rst_n, instr_valid, give_up, alu_update, alu_ovf_event, alu_err_event, dev_top, slow;
  logic alu_carry, alu_dyn_ovf, alu_link, ext_irq_top, instr_boundary, read_valid, switch_busy, fetch_req, pc_load;
  logic [3:0] dev_mid, ext_irq_mid, current_level, previous_level, pending_level_code;
  logic [10:0] int_src;
  logic [15:0] acc_in, live_program_counter, read_data, pc_out, status_word, s0, s5, s1;
  pli_op_t instr_op;
  pli_tgt_t instr_tgt;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  program_level_interrupt u_dut (.clk_sys, .rst_n, .ext_irq_mid, .ext_irq_top, .int_src, .instr_valid, .instr_op,
    .instr_tgt, .acc_in, .give_up, .instr_boundary, .live_program_counter, .alu_update, .alu_carry, .alu_dyn_ovf,
    .alu_ovf_event, .alu_err_event, .alu_link, .read_data, .read_valid, .current_level, .previous_level,
    .pending_level_code, .switch_busy, .fetch_req, .pc_load, .pc_out, .status_word);
  pli_src_model u_src (.clk_sys, .rst_n, .dev_mid, .dev_top, .slow, .switch_busy, .pc_load, .pc_out, .ext_irq_mid,
    .ext_irq_top, .instr_boundary, .live_program_counter);
  // clock and hang limit
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic xfer(input pli_op_t o, input pli_tgt_t t, input logic [15:0] a);
    @(posedge clk_sys);
    #2;
    instr_valid = 1'b1;
    instr_op = o;
    instr_tgt = t;
    acc_in = a;
    step(1);
    instr_valid = 1'b0;
  endtask
  task automatic rd(input pli_tgt_t t, input logic [15:0] e, input string n);
    xfer(PLI_OP_READ, t, 16'h0000);
    chk(n, e, read_data);
  endtask
  // waits for the fetch, recording the counter seen when the change starts
  task automatic wait_fetch(input logic [3:0] lvl, input logic [3:0] old, output logic [15:0] sv);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    sv = 16'h0000;
    while (fetch_req !== 1'b1 && n < PLI_SWITCH_MAX_CYC) begin
      step(1);
      if (switch_busy === 1'b1 && !got) begin
        sv = live_program_counter;
        got = 1'b1;
      end
      n++;
    end
    chk("fetch_in_time", 16'h0001, {15'h0, n < PLI_SWITCH_MAX_CYC});
    chk("new_level", {12'h0, lvl}, {12'h0, current_level});
    chk("prev_level", {12'h0, old}, {12'h0, previous_level});
  endtask
  task automatic t_regs();
    pli_tgt_t t;
    for (int i = 0; i < 2; i++) begin
      t = pli_tgt_t'(i);
      rd(t, 16'h0000, "reg_reset");
      xfer(PLI_OP_WRITE, t, 16'ha5a5);
      xfer(PLI_OP_MSET, t, 16'h0f00);
      xfer(PLI_OP_MCLR, t, 16'h00a5);
      rd(t, 16'haf00, "reg_ops");
      xfer(PLI_OP_WRITE, t, 16'h0000);
    end
    $display("t_regs done");
  endtask
  task automatic t_prio();
    logic [15:0] p [4] = '{16'h0001, 16'h0421, 16'h8001, 16'h4300};
    logic [3:0] e [4] = '{4'h0, 4'ha, 4'hf, 4'he};
    xfer(PLI_OP_WRITE, PLI_TGT_ENABLE, 16'hffff);
    for (int i = 0; i < 4; i++) begin
      xfer(PLI_OP_WRITE, PLI_TGT_DETECT, p[i]);
      step(1);
      chk("pending", {12'h0, e[i]}, {12'h0, pending_level_code});
    end
    xfer(PLI_OP_WRITE, PLI_TGT_ENABLE, 16'h03ff);
    step(1);
    chk("pending_masked", 16'h0009, {12'h0, pending_level_code});
    step(10);
    chk("no_raise_off", 16'h0000, {12'h0, current_level});
    xfer(PLI_OP_WRITE, PLI_TGT_DETECT, 16'h0000);
    $display("t_prio done");
  endtask
  task automatic drop();
    @(posedge clk_sys);
    #2;
    give_up = 1'b1;
    step(1);
    give_up = 1'b0;
  endtask
  task automatic t_switch();
    xfer(PLI_OP_WRITE, PLI_TGT_ENABLE, 16'hffff);
    xfer(PLI_OP_WRITE, PLI_TGT_DETECT, 16'h0020);
    xfer(PLI_OP_MSET, PLI_TGT_STATUS, 16'h0100);
    wait_fetch(4'h5, 4'h0, s0);
    slow = 1'b1;
    drop();
    wait_fetch(4'h0, 4'h5, s5);
    chk("pc_back_0", s0, pc_out);
    slow = 1'b0;
    xfer(PLI_OP_MSET, PLI_TGT_DETECT, 16'h0020);
    wait_fetch(4'h5, 4'h0, s1);
    chk("pc_back_5", s5, pc_out);
    drop();
    wait_fetch(4'h0, 4'h5, s1);
    xfer(PLI_OP_WRITE, PLI_TGT_ENABLE, 16'h0000);
    $display("t_switch done");
  endtask
  task automatic t_pins();
    dev_mid = 4'hf;
    dev_top = 1'b1;
    step(5);
    rd(PLI_TGT_DETECT, 16'hbc00, "pin_detect");
    dev_mid = 4'h0;
    dev_top = 1'b0;
    step(5);
    xfer(PLI_OP_WRITE, PLI_TGT_DETECT, 16'h0000);
    rd(PLI_TGT_DETECT, 16'h0000, "pin_clear");
    $display("t_pins done");
  endtask
  task automatic t_int();
    xfer(PLI_OP_WRITE, PLI_TGT_INT_ENABLE, 16'h0008);
    rd(PLI_TGT_INT_ENABLE, 16'h0008, "int_enable_rd");
    int_src = 11'h018;
    step(1);
    int_src = 11'h000;
    step(2);
    rd(PLI_TGT_DETECT, 16'h4000, "int_detect");
    rd(PLI_TGT_INT_CODE, 16'h0003, "int_code");
    xfer(PLI_OP_WRITE, PLI_TGT_DETECT, 16'h0000);
    step(2);
    rd(PLI_TGT_DETECT, 16'h0000, "int_after_code");
    xfer(PLI_OP_WRITE, PLI_TGT_INT_ENABLE, 16'h0000);
    $display("t_int done");
  endtask
  task automatic t_status();
    alu_update = 1'b1;
    {alu_carry, alu_dyn_ovf, alu_link, alu_ovf_event, alu_err_event} = 5'h1f;
    step(1);
    chk("dyn_flags", {4'h0, PLI_MACHINE_TYPE, 3'h1, 8'hf8}, status_word);
    {alu_carry, alu_dyn_ovf, alu_link, alu_ovf_event, alu_err_event} = 5'h00;
    step(1);
    alu_update = 1'b0;
    rd(PLI_TGT_STATUS, {4'h0, PLI_MACHINE_TYPE, 3'h1, 8'h28}, "sticky_flags");
    xfer(PLI_OP_MCLR, PLI_TGT_STATUS, 16'h0028);
    rd(PLI_TGT_STATUS, {4'h0, PLI_MACHINE_TYPE, 3'h1, 8'h00}, "flags_cleared");
    chk("status_port", {4'h0, PLI_MACHINE_TYPE, 3'h1, 8'h00}, status_word);
    xfer(PLI_OP_MSET, PLI_TGT_STATUS, 16'h0600);
    rd(PLI_TGT_STATUS, {4'h0, PLI_MACHINE_TYPE, 3'h7, 8'h00}, "mode_flags");
    xfer(PLI_OP_MCLR, PLI_TGT_STATUS, 16'h0600);
    $display("t_status done");
  endtask
  // reset, then the scenarios
  initial begin
    {instr_valid, give_up, alu_update, alu_ovf_event, alu_err_event, dev_top, slow} = '0;
    {alu_carry, alu_dyn_ovf, alu_link} = '0;
    dev_mid = 4'h0;
    int_src = 11'h000;
    acc_in = 16'h0000;
    instr_op = PLI_OP_READ;
    instr_tgt = PLI_TGT_ENABLE;
    rst_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    #2;
    rst_n = 1'b1;
    t_regs();
    t_prio();
    t_switch();
    t_pins();
    t_int();
    t_status();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
